// ---- hdl/aisrf_pkg.sv ----
// Purpose: shared constants and types for the converter input select block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   register offsets are byte addresses of aligned words
package aisrf_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SEL_IDX    = 8'h07; // selection register index
  localparam logic [7:0] SEL_ADDR   = 8'h1C; // index times four
  localparam logic [7:0] CTRL_ADDR  = 8'h20; // enable, start, bipolar
  localparam logic [7:0] STAT_ADDR  = 8'h24; // busy, shadow, long flag
  localparam logic [7:0] RES_ADDR   = 8'h28; // formatted result
  localparam logic [7:0] IRQS_ADDR  = 8'h2C; // sticky events
  localparam logic [7:0] IRQM_ADDR  = 8'h30; // event mask
  localparam logic [7:0] SEL_RST    = 8'h00;
  localparam int         REF_HI     = 7;
  localparam int         REF_LO     = 6;
  localparam int         CTL_EN     = 0;
  localparam int         CTL_START  = 1;
  localparam int         CTL_BIP    = 2;
  localparam int         IRQ_DONE   = 0;
  localparam int         IRQ_REFCHG = 1;
  // ---------------------------------------------------------------
  // conversion timing in converter clock cycles
  // ---------------------------------------------------------------
  localparam logic [4:0] CONV_SHORT = 5'd13;
  localparam logic [4:0] CONV_LONG  = 5'd25;
  localparam logic [9:0] UNI_MAX    = 10'h3FF;
  localparam logic [9:0] BIP_MIN    = 10'h200;
  localparam logic [9:0] BIP_MAX    = 10'h1FF;
  localparam logic [5:0] CH_AGND    = 6'h20;
  localparam logic [5:0] CH_IREF    = 6'h21;
  localparam logic [5:0] CH_TEMP    = 6'h22;

  typedef enum logic [1:0] {
    REF_SUPPLY = 2'b00,
    REF_EXTPIN = 2'b01,
    REF_INT11  = 2'b10,
    REF_RSVD   = 2'b11
  } aisrf_ref_e;

  typedef enum logic [2:0] {
    KIND_SINGLE = 3'b000,
    KIND_DIFF   = 3'b001,
    KIND_REV    = 3'b010,
    KIND_OFFCAL = 3'b011,
    KIND_GND    = 3'b100,
    KIND_IREF   = 3'b101,
    KIND_TEMP   = 3'b110
  } aisrf_kind_e;
endpackage : aisrf_pkg

// ---- hdl/aisrf_fmt_if.sv ----
// Purpose: carries raw sample and formatted result between modules
// Assumes: one clock domain
// Notes:   raw sample is a signed difference scaled to 10 bits
`timescale 1ns/100ps
interface aisrf_fmt_if;
  logic signed [10:0] rawDiff;
  logic               bipolar;
  logic               isDiff;
  logic        [9:0]  result;
  modport src (output rawDiff, output bipolar, output isDiff, input result);
  modport fmt (input rawDiff, input bipolar, input isDiff, output result);
endinterface : aisrf_fmt_if

// ---- hdl/aisrf_result_fmt.sv ----
// Purpose: formats a raw converter sample as unipolar or bipolar code
// Assumes: rawDiff already carries gain and reference scaling
// Notes:   purely combinational
`timescale 1ns/100ps
module aisrf_result_fmt (
  aisrf_fmt_if.fmt f
);
  // ---------------------------------------------------------------
  // saturating formatters
  // ---------------------------------------------------------------
  wire logic        negUni = f.rawDiff < 0;
  wire logic        hiUni  = f.rawDiff > 11'sd1023;
  wire logic        loBip  = f.rawDiff < -11'sd512;
  wire logic        hiBip  = f.rawDiff > 11'sd511;
  // negative difference saturates to zero in unipolar mode
  wire logic [9:0]  uniRes = negUni ? 10'h000 :
                             hiUni ? aisrf_pkg::UNI_MAX :
                             f.rawDiff[9:0];
  // two's complement, top bit is the sign
  wire logic [9:0]  bipRes = loBip ? aisrf_pkg::BIP_MIN :
                             hiBip ? aisrf_pkg::BIP_MAX :
                             f.rawDiff[9:0];
  assign f.result = (f.bipolar && f.isDiff) ? bipRes : uniRes;
endmodule : aisrf_result_fmt

// ---- hdl/aisrf_top.sv ----
// Purpose: input, reference and result format control of a 10-bit SAR
// Assumes: classic wishbone slave, core_clk 10 MHz, sync reset rst
// Notes:   converter clock tick arrives as a level, synchronised and edge-detected into a core_clk step
//
// Summary of operation
// - bipolar results span 0x200 to 0x1FF
// - bipolar top result bit is the sign
// - reset gives unipolar; bipolar bit allows negatives on differential inputs
// - unipolar clamps negative difference to zero
// - code 100010 routes and enables temperature sensor
// - reference field decodes supply, pin, 1.1V, reserved
// - reference change waits for conversion completion
// - conversion after reference change takes 25 cycles
// - channel change waits for conversion completion
// - low codes single ended, ground, reference
// - decode normal, reversed and offset pairs
// - code bit zero picks 1x or 20x
// - polarity bit swaps normal pair inputs
// - offset calibration pairs for inputs 0,3,7
`timescale 1ns/100ps
module aisrf_top (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               convTick,
  input  wire logic signed [10:0] sampleIn,
  output logic      [1:0]         refSel,
  output logic      [2:0]         posInput,
  output logic      [2:0]         negInput,
  output logic                    gain20x,
  output logic      [2:0]         inputKind,
  output logic                    tempSensorEn,
  output logic                    irq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  selReg_r;
  logic [7:0]  shadow_r;
  logic [2:0]  ctrl_r;
  logic        busy_r;
  logic        longNext_r;
  logic        longCur_r;
  logic [4:0]  cnt_r;
  logic [9:0]  result_r;
  logic [1:0]  irqStat_r;
  logic [1:0]  irqMask_r;
  logic        sampleA_r;
  logic        tickA_r;
  logic        tickB_r;
  logic signed [10:0] smpA_r;
  logic signed [10:0] smpB_r;

  // every check below runs on core_clk and sleeps through reset
  default clocking chkClk @(posedge core_clk); endclocking
  default disable iff (rst);

  aisrf_fmt_if fmtBus ();
  aisrf_result_fmt uFmt (.f(fmtBus.fmt));

  // ---------------------------------------------------------------
  // input synchronisers (tick and sample come from the analog side)
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tickA_r <= 1'b0;
      tickB_r <= 1'b0;
      smpA_r  <= '0;
      smpB_r  <= '0;
    end else begin
      tickA_r <= convTick;
      tickB_r <= tickA_r;
      smpA_r  <= sampleIn;
      smpB_r  <= smpA_r;
    end
  end
  // edge of the synchronised tick; one step per converter clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sampleA_r <= 1'b0;
    end else begin
      sampleA_r <= tickB_r;
    end
  end
  wire logic step = tickB_r & ~sampleA_r;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire logic req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wrReq  = req & wb_we_i & wb_sel_i[0];
  wire logic hitSel = wb_adr_i == aisrf_pkg::SEL_ADDR;
  wire logic hitCtl = wb_adr_i == aisrf_pkg::CTRL_ADDR;
  wire logic hitSt  = wb_adr_i == aisrf_pkg::STAT_ADDR;
  wire logic hitRes = wb_adr_i == aisrf_pkg::RES_ADDR;
  wire logic hitIs  = wb_adr_i == aisrf_pkg::IRQS_ADDR;
  wire logic hitIm  = wb_adr_i == aisrf_pkg::IRQM_ADDR;
  wire logic wrSel  = wrReq & hitSel;
  wire logic startW = wrReq & hitCtl & wb_dat_i[aisrf_pkg::CTL_START];
  wire logic refChg = wrSel &
      (wb_dat_i[7:6] != selReg_r[aisrf_pkg::REF_HI:aisrf_pkg::REF_LO]);
  wire logic enOn   = wrReq & hitCtl & wb_dat_i[aisrf_pkg::CTL_EN]
                      & ~ctrl_r[aisrf_pkg::CTL_EN];
  wire logic enabled = ctrl_r[aisrf_pkg::CTL_EN];
  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  wire logic [4:0] convLen = longCur_r ? aisrf_pkg::CONV_LONG
                                       : aisrf_pkg::CONV_SHORT;
  wire logic done  = busy_r & step & (cnt_r == convLen - 5'd1);
  wire logic start = startW & enabled & ~busy_r;
  // shadow loads when idle or at the completing step
  wire logic loadShadow = ~busy_r | done;

  // ---------------------------------------------------------------
  // bus registers and ack
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      selReg_r  <= aisrf_pkg::SEL_RST;
      ctrl_r    <= 3'b000;
      irqMask_r <= 2'b00;
      wb_ack_o  <= 1'b0;
    end else begin
      wb_ack_o <= req;
      if (wrSel) begin
        selReg_r <= wb_dat_i[7:0];
      end
      if (wrReq && hitCtl) begin
        ctrl_r <= {wb_dat_i[aisrf_pkg::CTL_BIP], 1'b0,
                   wb_dat_i[aisrf_pkg::CTL_EN]};
      end
      if (wrReq && hitIm) begin
        irqMask_r <= wb_dat_i[1:0];
      end
    end
  end

  // read mux; unmapped words read zero
  wire logic [31:0] rdData =
      hitSel ? {24'h0, selReg_r} :
      hitCtl ? {29'h0, ctrl_r[2], busy_r, ctrl_r[0]} :
      hitSt  ? {22'h0, longNext_r, busy_r, shadow_r} :
      hitRes ? {22'h0, result_r} :
      hitIs  ? {30'h0, irqStat_r} :
      hitIm  ? {30'h0, irqMask_r} : 32'h0;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0;
    end else begin
      wb_dat_o <= req ? rdData : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // conversion state, long-conversion flag and result capture
  // ---------------------------------------------------------------
  // reference changes or enabling the converter force a long run
  wire logic longNext_nxt = (refChg | enOn) ? 1'b1 :
                            start ? 1'b0 : longNext_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_r     <= 1'b0;
      cnt_r      <= 5'd0;
      longNext_r <= 1'b0;
      longCur_r  <= 1'b0;
      result_r   <= 10'h000;
      shadow_r   <= aisrf_pkg::SEL_RST;
    end else begin
      longNext_r <= longNext_nxt;
      if (!enabled) begin
        busy_r <= 1'b0;                    // disabling aborts a run
      end else if (start) begin
        busy_r    <= 1'b1;
        cnt_r     <= 5'd0;
        longCur_r <= longNext_r;
      end else if (done) begin
        busy_r   <= 1'b0;
        result_r <= fmtBus.result;
      end else if (busy_r && step) begin
        cnt_r <= cnt_r + 5'd1;
      end
      // mid-run writes are held off until completion
      if (loadShadow) begin
        shadow_r <= selReg_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status: set wins over write-one-to-clear
  // ---------------------------------------------------------------
  wire logic [1:0] evts = {refChg, done};
  wire logic [1:0] clr  = (wrReq && hitIs) ? wb_dat_i[1:0] : 2'b00;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqStat_r <= 2'b00;
      irq       <= 1'b0;
    end else begin
      irqStat_r <= (irqStat_r & ~clr) | evts;
      irq       <= |(((irqStat_r & ~clr) | evts) & irqMask_r);
    end
  end

  // ---------------------------------------------------------------
  // channel decode of the shadow selection
  // ---------------------------------------------------------------
  wire logic [5:0] code   = shadow_r[5:0];
  wire logic       isSe   = code[5:3] == 3'b000;
  wire logic       isNorm = ~code[5] & (code[4:3] != 2'b00);
  wire logic       isRevd = code[5] & (code[4:3] != 2'b00);
  wire logic       isCal  = (code >= 6'h23) && (code <= 6'h27);
  // pair table indexed by code bits 4:1, normal orientation
  function automatic logic [5:0] pairOf(input logic [3:0] idx);
    case (idx)
      4'h4:    pairOf = {3'd0, 3'd1};
      4'h5:    pairOf = {3'd0, 3'd3};
      4'h6:    pairOf = {3'd1, 3'd2};
      4'h7:    pairOf = {3'd1, 3'd3};
      4'h8:    pairOf = {3'd2, 3'd3};
      4'h9:    pairOf = {3'd3, 3'd4};
      4'hA:    pairOf = {3'd3, 3'd5};
      4'hB:    pairOf = {3'd3, 3'd6};
      4'hC:    pairOf = {3'd3, 3'd7};
      4'hD:    pairOf = {3'd4, 3'd5};
      4'hE:    pairOf = {3'd5, 3'd6};
      4'hF:    pairOf = {3'd6, 3'd7};
      default: pairOf = 6'h00;
    endcase
  endfunction : pairOf
  wire logic [5:0] pair = pairOf(code[4:1]);
  // offset calibration: 100011 -> 0, 10010x -> 3, 10011x -> 7
  wire logic [2:0] calIn = (code == 6'h23) ? 3'd0 :
                           code[1] ? 3'd7 : 3'd3;
  wire logic [2:0] posNxt = isSe ? code[2:0] :
                            isNorm ? pair[5:3] :
                            isRevd ? pair[2:0] :
                            isCal ? calIn : 3'd0;
  wire logic [2:0] negNxt = isNorm ? pair[2:0] :
                            isRevd ? pair[5:3] :
                            isCal ? calIn : 3'd0;
  wire logic       diffSel = isNorm | isRevd | isCal;
  wire logic       g20Nxt  = diffSel & (isCal ? (code != 6'h24 &&
                             code != 6'h26) : code[0]);
  wire logic [2:0] kindNxt =
      isSe   ? aisrf_pkg::KIND_SINGLE :
      isNorm ? aisrf_pkg::KIND_DIFF :
      isRevd ? aisrf_pkg::KIND_REV :
      isCal  ? aisrf_pkg::KIND_OFFCAL :
      (code == aisrf_pkg::CH_AGND) ? aisrf_pkg::KIND_GND :
      (code == aisrf_pkg::CH_IREF) ? aisrf_pkg::KIND_IREF :
      aisrf_pkg::KIND_TEMP;
  wire logic tempNxt = code == aisrf_pkg::CH_TEMP;

  assign fmtBus.rawDiff = smpB_r;
  assign fmtBus.bipolar = ctrl_r[aisrf_pkg::CTL_BIP];
  assign fmtBus.isDiff  = diffSel;

  // analog front-end outputs, registered from the shadow
  always_ff @(posedge core_clk) begin
    if (rst) begin
      refSel       <= aisrf_pkg::REF_SUPPLY;
      posInput     <= 3'd0;
      negInput     <= 3'd0;
      gain20x      <= 1'b0;
      inputKind    <= aisrf_pkg::KIND_SINGLE;
      tempSensorEn <= 1'b0;
    end else begin
      refSel       <= shadow_r[7:6];
      posInput     <= posNxt;
      negInput     <= negNxt;
      gain20x      <= g20Nxt;
      inputKind    <= kindNxt;
      tempSensorEn <= tempNxt;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  shadow_hold_a: assert property (
    busy_r && !done && enabled |=> $stable(shadow_r))
    else $error("shadow changed mid conversion");
  shadow_load_a: assert property (
    !busy_r |=> shadow_r == $past(selReg_r))
    else $error("shadow not loaded while idle");
  long_conv_a: assert property (
    refChg |=> longNext_r)
    else $error("reference change did not request long run");
  temp_route_a: assert property (
    shadow_r[5:0] == aisrf_pkg::CH_TEMP |=> tempSensorEn)
    else $error("temperature sensor not enabled");
  bip_range_a: assert property (
    fmtBus.bipolar && diffSel && smpB_r < -11'sd512
    |-> fmtBus.result == aisrf_pkg::BIP_MIN)
    else $error("bipolar low clamp wrong");
  bip_high_a: assert property (
    fmtBus.bipolar && diffSel && smpB_r > 11'sd511
    |-> fmtBus.result == aisrf_pkg::BIP_MAX)
    else $error("bipolar high clamp wrong");
  sign_bit_a: assert property (
    fmtBus.bipolar && diffSel |-> fmtBus.result[9] == (smpB_r < 0))
    else $error("bipolar sign bit wrong");
  uni_clamp_a: assert property (
    !fmtBus.bipolar && smpB_r < 0 |-> fmtBus.result == 10'h000)
    else $error("unipolar negative not zero");
  gain_bit_a: assert property (
    isNorm |=> gain20x == $past(code[0]))
    else $error("gain bit wrong");
  swap_pair_a: assert property (
    isRevd |=> posInput == $past(pair[2:0]) &&
               negInput == $past(pair[5:3]))
    else $error("reversed pair not swapped");
  single_route_a: assert property (
    isSe |=> inputKind == aisrf_pkg::KIND_SINGLE &&
             posInput == $past(code[2:0]))
    else $error("single ended input wrong");
  cal_pair_a: assert property (
    isCal |=> posInput == negInput)
    else $error("calibration pair not shorted");
endmodule : aisrf_top

// ---- test/aisrf_top_tb.sv ----
// Purpose: self-checking bench for the converter input select block
// Assumes: wishbone ack one cycle after the request, tick made here
// Notes:   tick period is 16 core clocks so a poll never spans a tick
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
  failures++; $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module aisrf_top_tb;
  // -------------------------------------------------------------
  // signals and design
  // -------------------------------------------------------------
  logic               core_clk;
  logic               rst;
  logic               cyc;
  logic               stb;
  logic               we;
  logic        [7:0]  adr;
  logic        [31:0] dat;
  logic        [3:0]  sel;
  logic        [31:0] rdat;
  logic               wbAck;
  logic signed [10:0] sampleIn;
  logic        [1:0]  refSel;
  logic        [2:0]  posInput;
  logic        [2:0]  negInput;
  logic               gain20x;
  logic        [2:0]  inputKind;
  logic               tempSensorEn;
  logic               irq;
  logic               convTick = 1'b0;
  logic        [3:0]  div      = 4'h0;
  logic        [3:0]  byteEn   = 4'hF;
  int                 ticks    = 0;
  int                 failures = 0;
  int                 checks   = 0;
  logic        [31:0] q;

  aisrf_top aisrf_top_inst (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(wbAck), .convTick(convTick),
    .sampleIn(sampleIn), .refSel(refSel), .posInput(posInput),
    .negInput(negInput), .gain20x(gain20x), .inputKind(inputKind),
    .tempSensorEn(tempSensorEn), .irq(irq)
  );

  // -------------------------------------------------------------
  // clock, converter tick and tick counter
  // -------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // counting on the same divider value keeps the count edge-exact
  always @(posedge core_clk) begin
    div <= div + 4'h1;
    convTick <= div[3];
    if (div == 4'h7) ticks <= ticks + 1;
  end

  // -------------------------------------------------------------
  // bus tasks
  // -------------------------------------------------------------
  // one classic cycle: hold until ack is sampled, take data there
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= byteEn;
    adr <= a;
    dat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    r = rdat;
    if (n >= 20) failures++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask : wb

  // write a selection while idle and check the decoded outputs
  task automatic selChk(input logic [7:0] v, input logic [2:0] k,
                        input logic [2:0] p, input logic [2:0] n,
                        input logic g, input logic t, input logic dn);
    logic [31:0] r;
    wb(1'b1, aisrf_pkg::SEL_ADDR, {24'h0, v}, r);
    repeat (3) @(posedge core_clk);
    `CHK("refSel", v[7:6], refSel)
    `CHK("kind", k, inputKind)
    `CHK("tempEn", t, tempSensorEn)
    if (k == 3'h0) `CHK("single", p, posInput)
    if (dn) begin
      `CHK("pos", p, posInput)
      `CHK("neg", n, negInput)
      `CHK("gain", g, gain20x)
    end
  endtask : selChk

  // start on a fixed tick phase, optionally reselect mid-run, poll done
  task automatic conv(input logic signed [10:0] s, input logic [31:0] c,
                      input int nt, input logic [9:0] res,
                      input logic [8:0] mid);
    logic [31:0] r;
    logic [1:0]  r0;
    logic [2:0]  k0;
    int          t0;
    int          n;
    sampleIn <= s;
    r0 = refSel;
    k0 = inputKind;
    while (div !== 4'hA) @(posedge core_clk);
    wb(1'b1, aisrf_pkg::CTRL_ADDR, c, r);
    t0 = ticks;
    if (mid[8]) begin
      wb(1'b1, aisrf_pkg::SEL_ADDR, {24'h0, mid[7:0]}, r);
      repeat (3) @(posedge core_clk);
      `CHK("heldRef", r0, refSel)
      `CHK("heldKind", k0, inputKind)
    end
    n = 0;
    r = 32'h100;
    while (r[8] !== 1'b0 && n < 300) begin
      wb(1'b0, aisrf_pkg::STAT_ADDR, 32'h0, r);
      n++;
    end
    if (n >= 300) failures++;
    `CHK("ticks", nt, ticks - t0)
    wb(1'b0, aisrf_pkg::RES_ADDR, 32'h0, r);
    `CHK("result", res, r[9:0])
    `CHK("signBit", res[9], r[9])
    repeat (2) @(posedge core_clk);
    if (mid[8]) `CHK("newRef", mid[7:6], refSel)
  endtask : conv

  // -------------------------------------------------------------
  // verdict
  // -------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // hang guard: the whole sequence needs well under 6000 clocks
  initial begin
    #(30000 * 100);
    failures++;
    report_and_stop;
  end

  // -------------------------------------------------------------
  // test sequence
  // -------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 8'h00;
    dat = 32'h0;
    sampleIn = 11'sh000;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    `CHK("rstRef", 2'h0, refSel)
    wb(1'b0, aisrf_pkg::SEL_ADDR, 32'h0, q);
    `CHK("selReset", 32'h0, q)
    wb(1'b0, aisrf_pkg::CTRL_ADDR, 32'h0, q);
    `CHK("bipReset", 1'b0, q[aisrf_pkg::CTL_BIP])
    wb(1'b1, aisrf_pkg::SEL_ADDR, 32'hFF, q);
    wb(1'b1, 8'h3C, 32'h55, q);
    wb(1'b0, 8'h3C, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    wb(1'b0, aisrf_pkg::SEL_ADDR, 32'h0, q);
    `CHK("selRw", 32'hFF, q)
    // a write without the low byte lane must leave the register alone
    byteEn = 4'hE;
    wb(1'b1, aisrf_pkg::SEL_ADDR, 32'h0, q);
    byteEn = 4'hF;
    wb(1'b0, aisrf_pkg::SEL_ADDR, 32'h0, q);
    `CHK("selByteEn", 32'hFF, q)
    // nothing drives the reference pin here, so any choice is safe
    // decode table: ref in bits 7:6, channel code below
    selChk(8'h05, 3'h0, 3'h5, 3'h0, 1'b0, 1'b0, 1'b0);
    selChk(8'h60, 3'h4, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    selChk(8'hA1, 3'h5, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    selChk(8'hA2, 3'h6, 3'h0, 3'h0, 1'b0, 1'b1, 1'b0);
    selChk(8'hC9, 3'h1, 3'h0, 3'h1, 1'b1, 1'b0, 1'b1);
    selChk(8'h29, 3'h2, 3'h1, 3'h0, 1'b1, 1'b0, 1'b1);
    selChk(8'h37, 3'h2, 3'h6, 3'h3, 1'b1, 1'b0, 1'b1);
    selChk(8'h23, 3'h3, 3'h0, 3'h0, 1'b1, 1'b0, 1'b1);
    selChk(8'h24, 3'h3, 3'h3, 3'h3, 1'b0, 1'b0, 1'b1);
    selChk(8'h26, 3'h3, 3'h7, 3'h7, 1'b0, 1'b0, 1'b1);
    selChk(8'h1D, 3'h1, 3'h5, 3'h6, 1'b1, 1'b0, 1'b1);
    selChk(8'h08, 3'h1, 3'h0, 3'h1, 1'b0, 1'b0, 1'b1);
    // clear events left by the reference changes above
    wb(1'b1, aisrf_pkg::IRQS_ADDR, 32'h3, q);
    // runs use the supply or pin reference, no settling wait
    wb(1'b1, aisrf_pkg::CTRL_ADDR, 32'h1, q);
    conv(11'sd300, 32'h3, 25, 10'h12C, 9'h0);
    wb(1'b0, aisrf_pkg::IRQS_ADDR, 32'h0, q);
    `CHK("doneFlag", 1'b1, q[aisrf_pkg::IRQ_DONE])
    `CHK("irqMasked", 1'b0, irq)
    wb(1'b1, aisrf_pkg::IRQM_ADDR, 32'h1, q);
    repeat (2) @(posedge core_clk);
    `CHK("irqOn", 1'b1, irq)
    wb(1'b1, aisrf_pkg::IRQS_ADDR, 32'h1, q);
    repeat (2) @(posedge core_clk);
    `CHK("irqOff", 1'b0, irq)
    wb(1'b0, aisrf_pkg::IRQS_ADDR, 32'h0, q);
    `CHK("doneClr", 1'b0, q[aisrf_pkg::IRQ_DONE])
    conv(-11'sd5, 32'h3, 13, 10'h000, 9'h0);
    conv(11'sd1023, 32'h3, 13, 10'h3FF, 9'h0);
    conv(-11'sd512, 32'h7, 13, 10'h200, 9'h0);
    conv(11'sd511, 32'h7, 13, 10'h1FF, 9'h0);
    conv(-11'sd700, 32'h7, 13, 10'h200, 9'h0);
    conv(11'sd700, 32'h7, 13, 10'h1FF, 9'h0);
    conv(-11'sd1, 32'h7, 13, 10'h3FF, 9'h143);
    wb(1'b0, aisrf_pkg::IRQS_ADDR, 32'h0, q);
    `CHK("refEvent", 1'b1, q[aisrf_pkg::IRQ_REFCHG])
    conv(-11'sd5, 32'h7, 25, 10'h000, 9'h0);
    report_and_stop;
  end
endmodule : aisrf_top_tb
